// ---- pkg/mss_pkg.sv ----
/*
 * constants and types for the mode and stack select block.
 * assumes a single 100 MHz core clock and a core that drives all requests.
 */
// Notes on behaviour
// - leave reset in application mode
// - exception return goes back to application mode
// - handler mode exactly while running handlers
// - stack pointer marks last pushed item
// - push decrements first, then stores
// - two independent stack pointer copies
// - handler mode always uses main stack
// - application mode: control bit picks stack
// - one privilege level only
// - no privilege faults in any mode
// - control bit 1: 0 main, 1 process
// - reset loads main pointer from address zero
// - reset loads pc from four, checks bit 0
package mss_pkg;
   localparam int          MSS_DW         = 32;
   localparam logic [31:0] MSS_VEC_SP     = 32'h0000_0000;
   localparam logic [31:0] MSS_VEC_PC     = 32'h0000_0004;
   localparam logic [31:0] MSS_WORD_BYTES = 32'h0000_0004;
   localparam int          MSS_CTRL_SPSEL = 1;
   localparam logic [31:0] MSS_ZERO       = 32'h0000_0000;
   localparam logic [31:0] MSS_PC_MASK    = 32'hFFFF_FFFE;
   localparam int          MSS_TBIT       = 0;

   typedef enum logic [1:0] {
      MSS_OP_NONE,
      MSS_OP_WRITE,
      MSS_OP_PUSH,
      MSS_OP_POP
   } mss_op_e;

   typedef enum {
      MSS_ST_FETCH_SP,
      MSS_ST_FETCH_PC,
      MSS_ST_RUN,
      MSS_ST_LOCKED
   } mss_state_e;
endpackage : mss_pkg

// ---- core/mss_sp_bank.sv ----
/*
 * two banked stack pointer copies with full-descending push and pop.
 * assumes the owner picks the copy and issues at most one op per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module mss_sp_bank (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire logic                  clkEn,
   // access
   input  wire logic                  selProcess,
   input  wire mss_pkg::mss_op_e      op,
   input  wire logic [31:0]           wrData,
   // results
   output logic      [31:0]           activeSp,
   output logic      [31:0]           pushAddr,
   output logic      [31:0]           mainSp,
   output logic      [31:0]           procSp
);
   import mss_pkg::*;

   typedef struct packed {
      logic [1:0][31:0] sp;
   } mss_bank_s;

   mss_bank_s bank_ff;
   mss_bank_s nxt_bank;

   ////////////////////////////////////////////////////////////////////////////
   // pushes use the decremented value as the store address
   assign activeSp = bank_ff.sp[selProcess];
   assign pushAddr = bank_ff.sp[selProcess] - MSS_WORD_BYTES;
   assign mainSp   = bank_ff.sp[0];
   assign procSp   = bank_ff.sp[1];

   always_comb begin
      nxt_bank = bank_ff;
      for (int i = 0; i < 2; i++) begin
         if (selProcess == i[0]) begin
            unique case (op)
               MSS_OP_WRITE: nxt_bank.sp[i] = wrData;
               MSS_OP_PUSH:  nxt_bank.sp[i] = bank_ff.sp[i] - MSS_WORD_BYTES;
               MSS_OP_POP:   nxt_bank.sp[i] = bank_ff.sp[i] + MSS_WORD_BYTES;
               MSS_OP_NONE:  nxt_bank.sp[i] = bank_ff.sp[i];
            endcase
         end
      end
   end

   // each copy only changes when selected
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_ff <= '0;
      end else if (clkEn) begin
         bank_ff <= nxt_bank;
      end
   end
endmodule : mss_sp_bank
`default_nettype wire

// ---- core/mss_mode_stack.sv ----
/*
 * operating mode tracker, reset vector fetch and stack pointer selection.
 * assumes the core's execution logic drives entry, return and stack ops,
 * and that memory answers a vector read with a one-cycle valid.
 */
`timescale 1ns/1ps
`default_nettype none
module mss_mode_stack (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire logic                  clkEn,
   // vector fetch memory port
   output logic                       vecRdReq,
   output logic      [31:0]           vecRdAddr,
   input  wire logic                  vecRdValid,
   input  wire logic [31:0]           vecRdData,
   // exception sequencing
   input  wire logic                  excEnter,
   input  wire logic                  excReturn,
   // control register write
   input  wire logic                  ctrlWr,
   input  wire logic [31:0]           ctrlWrData,
   // stack pointer access
   input  wire mss_pkg::mss_op_e      spOp,
   input  wire logic [31:0]           spWrData,
   // status
   output logic                       handlerMode,
   output logic                       useProcess,
   output logic                       privileged,
   output logic                       privFault,
   output logic                       coreRunning,
   output logic                       resetVecErr,
   output logic      [31:0]           controlReg,
   output logic      [31:0]           activeSp,
   output logic      [31:0]           pushAddr,
   output logic      [31:0]           mainStackPointer,
   output logic      [31:0]           processStackPointer,
   output logic      [31:0]           pcOut,
   output logic                       pcValid,
   output logic                       tBit
);
   import mss_pkg::*;

   typedef struct packed {
      mss_state_e  st;
      logic        handler;
      logic        spsel;
      logic        errVec;
      logic [31:0] pc;
      logic        pcVal;
      logic        tb;
      logic        rdReq;
      logic [31:0] rdAddr;
      logic [31:0] activeSp;
      logic [31:0] pushAddr;
      logic [31:0] mainSp;
      logic [31:0] procSp;
      logic        run;
      logic        useProc;
      logic        priv;
      logic        fault;
   } mss_state_s;

   mss_state_s st_ff;
   mss_state_s nxt_st;

   logic        selProc;
   logic        selProcNext;
   mss_op_e     bankOp;
   logic [31:0] bankWr;
   logic [31:0] bankActive;
   logic [31:0] bankPush;
   logic [31:0] bankMain;
   logic [31:0] bankProc;
   logic        running;

   ////////////////////////////////////////////////////////////////////////////
   // stack select: handler forces main, otherwise the control bit decides
   assign running = st_ff.run;
   assign selProc = running ? st_ff.useProc : 1'b0;

   always_comb begin
      bankOp = MSS_OP_NONE;
      bankWr = spWrData;
      if (st_ff.st == MSS_ST_FETCH_SP && vecRdValid) begin
         bankOp = MSS_OP_WRITE;
         bankWr = vecRdData;
      end else if (running) begin
         // ops outside the run state are dropped without any error flag
         bankOp = spOp;
      end
   end

   mss_sp_bank u_bank (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .clkEn      (clkEn),
      .selProcess (selProc),
      .op         (bankOp),
      .wrData     (bankWr),
      .activeSp   (bankActive),
      .pushAddr   (bankPush),
      .mainSp     (bankMain),
      .procSp     (bankProc)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state; registered copies of bank values lag by one cycle so that
   // every output stays a flop, trading a cycle of latency for clean timing
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.rdReq = 1'b0;
      nxt_st.pcVal = 1'b0;
      unique case (st_ff.st)
         MSS_ST_FETCH_SP: begin
            nxt_st.rdReq  = !vecRdValid;
            nxt_st.rdAddr = MSS_VEC_SP;
            if (vecRdValid) begin
               nxt_st.st     = MSS_ST_FETCH_PC;
               nxt_st.rdReq  = 1'b1;
               nxt_st.rdAddr = MSS_VEC_PC;
            end
         end

         MSS_ST_FETCH_PC: begin
            // an even vector locks the block until the next reset
            nxt_st.rdReq = !vecRdValid;
            if (vecRdValid) begin
               nxt_st.pc      = vecRdData & MSS_PC_MASK;
               nxt_st.tb      = vecRdData[MSS_TBIT];
               nxt_st.pcVal   = 1'b1;
               nxt_st.handler = 1'b0;
               nxt_st.errVec  = !vecRdData[MSS_TBIT];
               nxt_st.st      = vecRdData[MSS_TBIT] ? MSS_ST_RUN : MSS_ST_LOCKED;
            end
         end

         MSS_ST_RUN: begin
            // entry wins over a return arriving in the same cycle
            if (excEnter) begin
               nxt_st.handler = 1'b1;
            end else if (excReturn) begin
               nxt_st.handler = 1'b0;
            end
            if (ctrlWr) begin
               nxt_st.spsel = ctrlWrData[MSS_CTRL_SPSEL];
            end
         end

         MSS_ST_LOCKED: begin
            nxt_st.st = MSS_ST_LOCKED;
         end
      endcase

      // flags registered here so that each status output is a flop
      selProcNext    = !nxt_st.handler && nxt_st.spsel;
      nxt_st.useProc = selProcNext;
      nxt_st.run     = (nxt_st.st == MSS_ST_RUN);
      nxt_st.priv    = 1'b1;
      nxt_st.fault   = 1'b0;

      // mirrors follow the bank one edge late, whatever the op
      nxt_st.mainSp   = bankMain;
      nxt_st.procSp   = bankProc;
      nxt_st.activeSp = bankActive;
      nxt_st.pushAddr = bankPush;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; clkEn low holds every field, mirrors included
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff.st       <= MSS_ST_FETCH_SP;
         st_ff.handler  <= 1'b0;
         st_ff.spsel    <= 1'b0;
         st_ff.errVec   <= 1'b0;
         st_ff.pc       <= MSS_ZERO;
         st_ff.pcVal    <= 1'b0;
         st_ff.tb       <= 1'b0;
         st_ff.rdReq    <= 1'b1;
         st_ff.rdAddr   <= MSS_VEC_SP;
         st_ff.activeSp <= MSS_ZERO;
         st_ff.pushAddr <= MSS_ZERO;
         st_ff.mainSp   <= MSS_ZERO;
         st_ff.procSp   <= MSS_ZERO;
         st_ff.run      <= 1'b0;
         st_ff.useProc  <= 1'b0;
         st_ff.priv     <= 1'b1;
         st_ff.fault    <= 1'b0;
      end else if (clkEn) begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs; every one is a field of the state register
   assign vecRdReq            = st_ff.rdReq;
   assign vecRdAddr           = st_ff.rdAddr;

   // mode and control
   assign handlerMode         = st_ff.handler;
   assign useProcess          = st_ff.useProc;
   assign controlReg          = {30'h0000_0000, st_ff.spsel, 1'b0};

   // one privilege level: never privileged-restricted, never faults
   assign privileged          = st_ff.priv;
   assign privFault           = st_ff.fault;

   // run state and reset vector results
   assign coreRunning         = st_ff.run;
   assign resetVecErr         = st_ff.errVec;
   assign pcOut               = st_ff.pc;
   assign pcValid             = st_ff.pcVal;
   assign tBit                = st_ff.tb;

   // stack pointer mirrors, one edge behind the bank
   assign activeSp            = st_ff.activeSp;
   assign pushAddr            = st_ff.pushAddr;
   assign mainStackPointer    = st_ff.mainSp;
   assign processStackPointer = st_ff.procSp;
endmodule : mss_mode_stack
`default_nettype wire

// ---- tb/mss_mode_stack_props.sv ----
/* assertions on the ports of the mode and stack select block.
   assumes the bind below and one clock domain with active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module mss_mode_stack_props (
   // clock and reset
   input wire logic             ref_clk,
   input wire logic             rst_n,
   input wire logic             clkEn,
   // requests
   input wire logic             excEnter,
   input wire logic             excReturn,
   input wire logic             ctrlWr,
   input wire mss_pkg::mss_op_e spOp,
   // status
   input wire logic             handlerMode,
   input wire logic             useProcess,
   input wire logic             privileged,
   input wire logic             privFault,
   input wire logic             coreRunning,
   input wire logic             resetVecErr,
   input wire logic [31:0]      controlReg,
   input wire logic [31:0]      activeSp,
   input wire logic [31:0]      mainStackPointer,
   input wire logic [31:0]      processStackPointer,
   input wire logic [31:0]      pcOut,
   input wire logic             pcValid,
   input wire logic             tBit
);
   import mss_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   // quiet: no selection change this cycle, so mirrored pointers are comparable
   wire quiet = coreRunning && clkEn && !excEnter && !excReturn && !ctrlWr;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   chk_thread_boot: assert property ($rose(coreRunning) |-> !handlerMode)
      else $error("handler mode at start");
   chk_enter_handler: assert property (coreRunning && clkEn && excEnter |=> handlerMode)
      else $error("no handler mode after entry");
   chk_return_thread: assert property (
      coreRunning && clkEn && excReturn && !excEnter |=> !handlerMode)
      else $error("still handler mode after return");
   chk_handler_main: assert property (handlerMode |-> !useProcess)
      else $error("process stack in handler mode");
   chk_thread_sel: assert property (
      coreRunning && !handlerMode |-> useProcess == controlReg[MSS_CTRL_SPSEL])
      else $error("stack select not following control bit");
   chk_push_dec: assert property (
      quiet && spOp == MSS_OP_PUSH && $past(spOp) == MSS_OP_NONE && $stable(useProcess)
      |-> ##2 activeSp == $past(activeSp, 2) - MSS_WORD_BYTES)
      else $error("push did not decrement by four");
   chk_other_copy: assert property (
      quiet && spOp != MSS_OP_NONE && useProcess && $past(spOp) == MSS_OP_NONE
      |-> ##2 $stable(mainStackPointer))
      else $error("main copy changed by process access");
   // mirrors lag one edge, so the copy is picked by last cycle's selection
   chk_active_copy: assert property (
      $past(clkEn) |-> activeSp == (($past(coreRunning) && $past(useProcess))
      ? processStackPointer : mainStackPointer))
      else $error("active pointer not the selected copy");
   chk_one_level: assert property (privileged && !privFault)
      else $error("privilege level or fault seen");
   chk_pc_load: assert property (
      pcValid |-> !pcOut[0] && tBit == coreRunning && tBit != resetVecErr)
      else $error("reset vector load wrong");
endmodule : mss_mode_stack_props
bind mss_mode_stack mss_mode_stack_props u_mss_mode_stack_props (
   .ref_clk             (ref_clk),
   .rst_n               (rst_n),
   .clkEn               (clkEn),
   .excEnter            (excEnter),
   .excReturn           (excReturn),
   .ctrlWr              (ctrlWr),
   .spOp                (spOp),
   .handlerMode         (handlerMode),
   .useProcess          (useProcess),
   .privileged          (privileged),
   .privFault           (privFault),
   .coreRunning         (coreRunning),
   .resetVecErr         (resetVecErr),
   .controlReg          (controlReg),
   .activeSp            (activeSp),
   .mainStackPointer    (mainStackPointer),
   .processStackPointer (processStackPointer),
   .pcOut               (pcOut),
   .pcValid             (pcValid),
   .tBit                (tBit)
);
`default_nettype wire

// ---- tb/mss_mode_stack_tb.sv ----
/* self-checking bench for the mode and stack select block.
   assumes vector memory answers with one-cycle valid pulses. */
`timescale 1ns/1ps
`default_nettype none
module mss_mode_stack_tb;
   import mss_pkg::*;
   logic        ref_clk = 0, rst_n = 0, clkEn = 1, vecRdValid = 0;
   logic        excEnter = 0, excReturn = 0, ctrlWr = 0;
   logic [31:0] vecRdData = 32'h0, ctrlWrData = 32'h0, spWrData = 32'h0;
   mss_op_e     spOp = MSS_OP_NONE;
   logic        vecRdReq, handlerMode, useProcess, privileged, privFault;
   logic        coreRunning, resetVecErr, pcValid, tBit;
   logic [31:0] vecRdAddr, controlReg, activeSp, pushAddr, mainStackPointer;
   logic [31:0] processStackPointer, pcOut;
   int          errors = 0, check_count = 0;
   mss_mode_stack u_mss_mode_stack (
      .ref_clk             (ref_clk),
      .rst_n               (rst_n),
      .clkEn               (clkEn),
      .vecRdReq            (vecRdReq),
      .vecRdAddr           (vecRdAddr),
      .vecRdValid          (vecRdValid),
      .vecRdData           (vecRdData),
      .excEnter            (excEnter),
      .excReturn           (excReturn),
      .ctrlWr              (ctrlWr),
      .ctrlWrData          (ctrlWrData),
      .spOp                (spOp),
      .spWrData            (spWrData),
      .handlerMode         (handlerMode),
      .useProcess          (useProcess),
      .privileged          (privileged),
      .privFault           (privFault),
      .coreRunning         (coreRunning),
      .resetVecErr         (resetVecErr),
      .controlReg          (controlReg),
      .activeSp            (activeSp),
      .pushAddr            (pushAddr),
      .mainStackPointer    (mainStackPointer),
      .processStackPointer (processStackPointer),
      .pcOut               (pcOut),
      .pcValid             (pcValid),
      .tBit                (tBit)
   );
   always #5 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic vec(input logic [31:0] d);
      @(posedge ref_clk);
      vecRdValid <= 1'b1;
      vecRdData  <= d;
      @(posedge ref_clk);
      vecRdValid <= 1'b0;
      #1;
   endtask : vec
   // k = {ctrlWr, excReturn, excEnter}; mirrors settle one edge after state
   task automatic pulse(input logic [2:0] k, input logic [31:0] d);
      @(posedge ref_clk);
      {ctrlWr, excReturn, excEnter} <= k;
      ctrlWrData <= d;
      @(posedge ref_clk);
      {ctrlWr, excReturn, excEnter} <= 3'h0;
      tick(1);
   endtask : pulse
   task automatic op(input mss_op_e o, input logic [31:0] d);
      @(posedge ref_clk);
      spOp     <= o;
      spWrData <= d;
      @(posedge ref_clk);
      spOp <= MSS_OP_NONE;
      tick(1);
   endtask : op
   ////////////////////////////////////////////////////////////////////////////////
   task automatic boot;
      chk("vecRdAddr", {vecRdAddr[31:1], vecRdReq}, 32'h1);
      vec(32'h2000_1000);
      chk("vecRdAddr", vecRdAddr, MSS_VEC_PC);
      vec(32'h0000_0101);
      chk("pcOut", pcOut, 32'h0000_0100);
      chk("tBit", {pcValid, tBit, coreRunning}, 32'h7);
      chk("handlerMode", handlerMode, 32'h0);
      chk("resetVecErr", resetVecErr, 32'h0);
      tick(1);
      chk("mainSp", mainStackPointer, 32'h2000_1000);
   endtask : boot
   task automatic banks;
      op(MSS_OP_WRITE, 32'h2000_0800);
      chk("mainSp", mainStackPointer, 32'h2000_0800);
      chk("procSp", processStackPointer, 32'h0);
      pulse(3'h4, 32'h0000_0002);
      chk("useProcess", useProcess, 32'h1);
      op(MSS_OP_WRITE, 32'h2000_0400);
      op(MSS_OP_PUSH, 32'h0);
      chk("procSp", processStackPointer, 32'h2000_03FC);
      chk("pushAddr", pushAddr, 32'h2000_03F8);
      chk("mainSp", mainStackPointer, 32'h2000_0800);
   endtask : banks
   task automatic modes;
      pulse(3'h1, 32'h0);
      chk("handlerMode", handlerMode, 32'h1);
      chk("activeSp", activeSp, 32'h2000_0800);
      chk("privilege", {privileged, privFault}, 32'h2);
      op(MSS_OP_PUSH, 32'h0);
      chk("mainSp", mainStackPointer, 32'h2000_07FC);
      chk("procSp", processStackPointer, 32'h2000_03FC);
      pulse(3'h2, 32'h0);
      chk("handlerMode", handlerMode, 32'h0);
      chk("activeSp", activeSp, 32'h2000_03FC);
      chk("privilege", {privileged, privFault}, 32'h2);
      op(MSS_OP_POP, 32'h0);
      chk("procSp", processStackPointer, 32'h2000_0400);
      pulse(3'h4, 32'h0);
      chk("activeSp", activeSp, 32'h2000_07FC);
   endtask : modes
   // clkEn low for one edge: the push and the entry beside it must be lost
   task automatic freeze;
      @(posedge ref_clk);
      clkEn    <= 1'b0;
      spOp     <= MSS_OP_PUSH;
      excEnter <= 1'b1;
      @(posedge ref_clk);
      clkEn    <= 1'b1;
      spOp     <= MSS_OP_NONE;
      excEnter <= 1'b0;
      tick(2);
      chk("mainSp", mainStackPointer, 32'h2000_07FC);
      chk("handlerMode", handlerMode, 32'h0);
   endtask : freeze
   // mid-run reset, then an even reset vector locks the block
   task automatic lockout;
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      tick(1);
      chk("vecRdAddr", {vecRdAddr[31:1], vecRdReq}, 32'h1);
      chk("mainSp", mainStackPointer, 32'h0);
      chk("handlerMode", {handlerMode, coreRunning}, 32'h0);
      vec(32'h2000_2000);
      vec(32'h0000_0200);
      chk("resetVecErr", {resetVecErr, coreRunning, tBit}, 32'h4);
      op(MSS_OP_WRITE, 32'h1000_0000);
      chk("mainSp", mainStackPointer, 32'h2000_2000);
   endtask : lockout
   task automatic end_of_test;
      if (errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      tick(1);
      boot();
      banks();
      modes();
      freeze();
      lockout();
      end_of_test();
   end
endmodule : mss_mode_stack_tb
`default_nettype wire
